// File: common/palette_pkg.sv
// shared constants and carriers for the palette pixel input stage
package palette_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int IDX_W = 8;
  localparam int OVL_W = 4;
  localparam int COL_W = 24;
  localparam int PAL_ENTRIES = 256;
  localparam int OVL_ENTRIES = 15;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] PAL_ADDR_OFS = 12'h004;
  localparam logic [11:0] PAL_DATA_OFS = 12'h008;
  localparam logic [11:0] OVL_ADDR_OFS = 12'h00c;
  localparam logic [11:0] OVL_DATA_OFS = 12'h010;
  localparam logic [11:0] STATUS_OFS = 12'h014;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] PAL_ADDR_RST = 8'h00;
  localparam logic [3:0] OVL_ADDR_RST = 4'h1;
  localparam logic [3:0] OVL_NONE = 4'h0;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync_n;
    logic blank_n;
    logic [3:0] ovl;
    logic [7:0] idx;
  } pix_word_t;

  typedef struct packed {
    logic [23:0] colour;
    logic blank;
    logic sync_on;
    logic pedestal;
  } out_word_t;

endpackage : palette_pkg

// File: design/colour_store.sv
// palette ram and overlay colour registers
`timescale 1ns/1ps
module colour_store
  import palette_pkg::*;
#(
  parameter int ENTRIES = PAL_ENTRIES,
  parameter int OVLS = OVL_ENTRIES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_pal_in,
  input wire logic wr_ovl_in,
  input wire logic [7:0] pal_addr_in,
  input wire logic [3:0] ovl_addr_in,
  input wire logic [23:0] wdata_in,
  input wire logic [7:0] pix_idx_in,
  input wire logic [3:0] pix_ovl_in,
  output logic [23:0] pix_colour_out,
  output logic [23:0] pal_rdata_out,
  output logic [23:0] ovl_rdata_out
);
  logic [23:0] pal_mem [ENTRIES];
  logic [23:0] ovl_mem [1:OVLS];

  wire ovl_hit = (pix_ovl_in != OVL_NONE);
  wire ovl_wr_ok = (ovl_addr_in != OVL_NONE);

  // overlay wins over the index; overlay 0 is the palette path
  assign pix_colour_out = ovl_hit ? ovl_mem[pix_ovl_in]
                                  : pal_mem[pix_idx_in];
  assign pal_rdata_out = pal_mem[pal_addr_in];
  assign ovl_rdata_out = ovl_wr_ok ? ovl_mem[ovl_addr_in] : 24'h00_0000;

  always_ff @(posedge clk_in) begin
    if (wr_pal_in) pal_mem[pal_addr_in] <= wdata_in;
    if (wr_ovl_in && ovl_wr_ok) ovl_mem[ovl_addr_in] <= wdata_in;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pal_lookup;
    @(posedge clk_in) disable iff (!rstn_in)
    (wr_pal_in ##1 (pix_ovl_in == OVL_NONE && !wr_pal_in
      && pix_idx_in == $past(pal_addr_in)))
    |-> pix_colour_out == $past(wdata_in);
  endproperty
  a_pal_lookup: assert property (p_pal_lookup)
    else $error("palette entry not used for index");

  property p_ovl_lookup;
    @(posedge clk_in) disable iff (!rstn_in)
    ((wr_ovl_in && ovl_wr_ok) ##1 (!wr_ovl_in
      && pix_ovl_in == $past(ovl_addr_in)))
    |-> pix_colour_out == $past(wdata_in);
  endproperty
  a_ovl_lookup: assert property (p_ovl_lookup)
    else $error("overlay colour not selected");
endmodule : colour_store

// File: design/fifo_buf.sv
// small ready/valid fifo for captured pixel words
`timescale 1ns/1ps
module fifo_buf
  import palette_pkg::*;
#(
  parameter int W = 14,
  parameter int D = FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [$clog2(D+1)-1:0] count_out
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D+1);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(D-1)) ? '0 : AW'(p + 1'b1);
  endfunction : next_ptr

  wire push = ce_in & in_valid_in & in_ready_out;
  wire pop = ce_in & out_valid_out & out_ready_in;

  assign in_ready_out = (cnt_q != CW'(D));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rp_q];
  assign count_out = cnt_q;

  always_ff @(posedge clk_in) begin
    if (push) mem_q[wp_q] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= next_ptr(wp_q);
      if (pop) rp_q <= next_ptr(rp_q);
      if (push && !pop) cnt_q <= CW'(cnt_q + 1'b1);
      else if (pop && !push) cnt_q <= CW'(cnt_q - 1'b1);
    end
  end
endmodule : fifo_buf

// File: design/palette_pixel_input_control.sv
// pixel input stage of the palette converter with apb register port
// ------------------------------------------------------------------
// Summary of operation
// - blank low forces blanking level outputs
// - blank captured on each rising clock; the code captures it only on a rising clock that takes a pixel word
// - blanked pixel ignores index and overlay
// - pedestal select gives 0 or 7.5 IRE
// - sync low removes 40 IRE current
// - sync does not override other inputs
// - sync captured on each rising clock; the code captures it only on a rising clock that takes a pixel word
// - 8-bit index picks one of 256 entries
// - overlay selection ignores pixel index
// - overlay 0 uses palette, 1-15 overlays
// ------------------------------------------------------------------
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module palette_pixel_input_control
  import palette_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pixel stream in
  input wire logic pixel_valid_in,
  output logic pixel_ready_out,
  input wire logic [7:0] pixel_index_in,
  input wire logic [3:0] overlay_select_in,
  input wire logic sync_n_in,
  input wire logic blank_n_in,
  input wire logic pedestal_sel_in,
  // drive codes toward the current outputs
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [23:0] colour_current_outputs_out,
  output logic blank_level_out,
  output logic sync_current_out,
  output logic pedestal_out
);
  localparam int PW = $bits(pix_word_t);
  localparam int CNT_W = $clog2(DEPTH+1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic shows_colour(input pix_word_t w,
                                        input logic en);
    shows_colour = w.blank_n & en;
  endfunction : shows_colour

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire sel_ctrl = (paddr_in == CTRL_OFS);
  wire sel_paddr = (paddr_in == PAL_ADDR_OFS);
  wire sel_pdata = (paddr_in == PAL_DATA_OFS);
  wire sel_oaddr = (paddr_in == OVL_ADDR_OFS);
  wire sel_odata = (paddr_in == OVL_DATA_OFS);
  wire sel_stat = (paddr_in == STATUS_OFS);
  wire hit = sel_ctrl | sel_paddr | sel_pdata | sel_oaddr | sel_odata
             | sel_stat;
  // the whole slave freezes with the clock enable
  wire done = access & ce_in;
  wire wr_done = done & pwrite_in & hit;
  wire rd_done = done & ~pwrite_in & hit;
  wire wr_pal = wr_done & sel_pdata;
  wire wr_ovl = wr_done & sel_odata;
  wire step_pal = (wr_done | rd_done) & sel_pdata;
  wire step_ovl = (wr_done | rd_done) & sel_odata;

  assign pready_out = access & ce_in;
  assign pslverr_out = access & ce_in & ~hit;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic en_q;
  logic [7:0] pal_addr_q;
  logic [3:0] ovl_addr_q;
  logic [31:0] prdata_q;
  logic [23:0] pal_rdata;
  logic [23:0] ovl_rdata;
  logic [CNT_W-1:0] fifo_cnt;
  pix_word_t last_q;

  // overlay address skips the unused slot 0 when it wraps
  wire [3:0] ovl_next = (ovl_addr_q == 4'hf) ? OVL_ADDR_RST
                                            : 4'(ovl_addr_q + 4'h1);
  wire [31:0] stat_word = {8'h00, 4'(fifo_cnt), 6'h00,
                           last_q.sync_n, last_q.blank_n,
                           last_q.ovl, last_q.idx};
  wire [31:0] rd_mux =
    sel_ctrl  ? {31'h0000_0000, en_q} :
    sel_paddr ? {24'h00_0000, pal_addr_q} :
    sel_pdata ? {8'h00, pal_rdata} :
    sel_oaddr ? {28'h000_0000, ovl_addr_q} :
    sel_odata ? {8'h00, ovl_rdata} :
    sel_stat  ? stat_word : UNMAPPED_RD;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_q <= CTRL_EN_RST;
      pal_addr_q <= PAL_ADDR_RST;
      ovl_addr_q <= OVL_ADDR_RST;
    end else begin
      if (wr_done && sel_ctrl) en_q <= pwdata_in[CTRL_EN_BIT];
      if (wr_done && sel_paddr) pal_addr_q <= pwdata_in[7:0];
      else if (step_pal) pal_addr_q <= 8'(pal_addr_q + 8'h01);
      if (wr_done && sel_oaddr) ovl_addr_q <= pwdata_in[3:0];
      else if (step_ovl) ovl_addr_q <= ovl_next;
    end
  end

  // read data is staged in the setup cycle, before any address step
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) prdata_q <= UNMAPPED_RD;
    else if (ce_in && setup) prdata_q <= rd_mux;
  end
  assign prdata_out = prdata_q;

  // ----------------------------------------------------------------
  // input capture
  // ----------------------------------------------------------------
  pix_word_t cap_q;
  logic cap_v_q;
  pix_word_t f_w;
  logic [PW-1:0] f_bits;
  logic f_in_ready;
  logic f_valid;
  logic o_v_q;
  out_word_t o_q;

  wire take = ce_in & pixel_valid_in & pixel_ready_out;
  wire cap_push = ce_in & cap_v_q & f_in_ready;
  wire pix_word_t in_word = '{sync_n: sync_n_in, blank_n: blank_n_in,
                              ovl: overlay_select_in,
                              idx: pixel_index_in};

  assign pixel_ready_out = ce_in & (~cap_v_q | f_in_ready);

  // index, overlay, sync and blank share one capture edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cap_q <= '0;
      cap_v_q <= 1'b0;
      last_q <= '0;
    end else begin
      if (take) cap_q <= in_word;
      if (take) last_q <= in_word;
      if (take) cap_v_q <= 1'b1;
      else if (cap_push) cap_v_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // buffer and lookup
  // ----------------------------------------------------------------
  fifo_buf #(
    .W(PW),
    .D(DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .in_valid_in(cap_v_q),
    .in_ready_out(f_in_ready),
    .in_data_in(cap_q),
    .out_valid_out(f_valid),
    .out_ready_in(~o_v_q | out_ready_in),
    .out_data_out(f_bits),
    .count_out(fifo_cnt)
  );
  assign f_w = pix_word_t'(f_bits);

  logic [23:0] look;
  colour_store u_store (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_pal_in(wr_pal),
    .wr_ovl_in(wr_ovl),
    .pal_addr_in(pal_addr_q),
    .ovl_addr_in(ovl_addr_q),
    .wdata_in(pwdata_in[23:0]),
    .pix_idx_in(f_w.idx),
    .pix_ovl_in(f_w.ovl),
    .pix_colour_out(look),
    .pal_rdata_out(pal_rdata),
    .ovl_rdata_out(ovl_rdata)
  );

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  wire fire = ce_in & f_valid & (~o_v_q | out_ready_in);
  wire show = shows_colour(f_w, en_q);
  // blank drops index and overlay; sync only drops its own current
  wire out_word_t o_d = '{
    colour: show ? look : 24'h00_0000,
    blank: ~show,
    sync_on: f_w.sync_n,
    pedestal: pedestal_sel_in & show};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      o_q <= '{colour: 24'h00_0000, blank: 1'b1, sync_on: 1'b1,
               pedestal: 1'b0};
      o_v_q <= 1'b0;
    end else begin
      if (fire) o_q <= o_d;
      if (fire) o_v_q <= 1'b1;
      else if (ce_in && out_ready_in) o_v_q <= 1'b0;
    end
  end

  assign out_valid_out = o_v_q;
  assign colour_current_outputs_out = o_q.colour;
  assign blank_level_out = o_q.blank;
  assign sync_current_out = o_q.sync_on;
  assign pedestal_out = o_q.pedestal;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_blank_forces;
    fire && !f_w.blank_n |=> blank_level_out
      && colour_current_outputs_out == 24'h00_0000 && !pedestal_out;
  endproperty
  a_blank_forces: assert property (p_blank_forces)
    else $error("blanked pixel not at blanking level");

  property p_blank_capture;
    take |=> cap_q.blank_n == $past(blank_n_in) && cap_v_q;
  endproperty
  a_blank_capture: assert property (p_blank_capture)
    else $error("blank input not captured");

  property p_blank_ignores;
    fire && !f_w.blank_n ##1 fire && !f_w.blank_n
      |=> $stable(colour_current_outputs_out);
  endproperty
  a_blank_ignores: assert property (p_blank_ignores)
    else $error("blanked output depends on pixel inputs");

  property p_pedestal;
    fire |=> pedestal_out == ($past(pedestal_sel_in) && !blank_level_out);
  endproperty
  a_pedestal: assert property (p_pedestal)
    else $error("pedestal not as selected");

  property p_sync_off;
    fire |=> sync_current_out == $past(f_w.sync_n);
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync current not following sync");

  property p_sync_no_override;
    fire && !f_w.sync_n && f_w.blank_n && en_q
      |=> !blank_level_out && colour_current_outputs_out == $past(look);
  endproperty
  a_sync_no_override: assert property (p_sync_no_override)
    else $error("sync overrode colour");

  property p_sync_capture;
    take |=> cap_q.sync_n == $past(sync_n_in);
  endproperty
  a_sync_capture: assert property (p_sync_capture)
    else $error("sync input not captured");

  property p_aligned;
    take |=> cap_q.idx == $past(pixel_index_in)
      && cap_q.ovl == $past(overlay_select_in);
  endproperty
  a_aligned: assert property (p_aligned)
    else $error("index and overlay not captured together");

  property p_out_hold;
    out_valid_out && !out_ready_in |=> out_valid_out
      && $stable(colour_current_outputs_out) && $stable(blank_level_out);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output changed while stalled");

  // zero wait states, and read data must be the word staged at setup
  property p_apb_answer;
    setup && ce_in ##1 access && ce_in
      |-> pready_out && prdata_out == $past(rd_mux);
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb access not answered");

  property p_pal_step;
    step_pal |=> pal_addr_q == 8'($past(pal_addr_q) + 8'h01);
  endproperty
  a_pal_step: assert property (p_pal_step)
    else $error("palette address did not step");

  property p_ovl_wrap;
    step_ovl && ovl_addr_q == 4'hf |=> ovl_addr_q == OVL_ADDR_RST;
  endproperty
  a_ovl_wrap: assert property (p_ovl_wrap)
    else $error("overlay address did not skip slot 0");

  property p_disabled_blanks;
    fire && !en_q |=> blank_level_out && !pedestal_out;
  endproperty
  a_disabled_blanks: assert property (p_disabled_blanks)
    else $error("disabled converter not blanking");

  // a held capture must survive a full buffer, or a word is lost
  property p_capture_hold;
    cap_v_q && !cap_push |=> cap_v_q && $stable(cap_q);
  endproperty
  a_capture_hold: assert property (p_capture_hold)
    else $error("held capture overwritten");

  // low enable freezes the whole pipeline, output included
  property p_ce_freeze;
    !ce_in |=> $stable(o_q) && $stable(o_v_q) && $stable(fifo_cnt)
      && $stable(cap_q);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved while enable low");

  c_blank: cover property (fire && !f_w.blank_n);
  c_overlay: cover property (fire && f_w.blank_n && f_w.ovl != OVL_NONE);
  c_sync: cover property (fire && !f_w.sync_n);
  c_full: cover property (!f_in_ready ##1 out_ready_in);
  c_ce_hold: cover property (!ce_in && out_valid_out);
endmodule : palette_pixel_input_control

// File: sim/palette_pixel_input_control_tb_top.sv
// self-checking bench for the palette pixel input stage
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module palette_pixel_input_control_tb_top;
  import palette_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, pvalid, pready_pix, ped = 1'b1;
  logic out_ready = 1'b1, out_valid, blank_l, sync_c, ped_o, en_v = 1'b1;
  logic ce = 1'b1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [23:0] colour, c;
  logic [23:0] pal_m [256];
  logic [23:0] ovl_m [16];
  logic err;
  pix_word_t w;
  out_word_t e;
  out_word_t exp_q[$];
  int fail_count = 0, checks = 0, n;
  initial forever #2.5 clk_in = ~clk_in;
  palette_pixel_input_control u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .ce_in(ce), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pixel_valid_in(pvalid),
    .pixel_ready_out(pready_pix), .pixel_index_in(w.idx),
    .overlay_select_in(w.ovl), .sync_n_in(w.sync_n),
    .blank_n_in(w.blank_n), .pedestal_sel_in(ped),
    .out_valid_out(out_valid), .out_ready_in(out_ready),
    .colour_current_outputs_out(colour), .blank_level_out(blank_l),
    .sync_current_out(sync_c), .pedestal_out(ped_o));
  pixel_source u_src (.clk_in(clk_in), .rstn_in(rstn_in),
    .ready_in(pready_pix), .valid_out(pvalid), .word_out(w));
  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      summarize();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps psel from being driven twice in one step
    @(posedge clk_in);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    `CHK("rdata", x, r)
    `CHK("rd_err", 1'b0, err)
  endtask : rd
  function automatic out_word_t exp_word(pix_word_t p);
    out_word_t o;
    o.blank = !p.blank_n || !en_v;
    o.colour = o.blank ? 24'h0 : (p.ovl != 4'h0 ? ovl_m[p.ovl] : pal_m[p.idx]);
    o.sync_on = p.sync_n;
    o.pedestal = ped & !o.blank;
    return o;
  endfunction : exp_word
  task automatic px(input logic [7:0] i, input logic [3:0] o,
                    input logic s, input logic b);
    pix_word_t p;
    p = '{sync_n: s, blank_n: b, ovl: o, idx: i};
    u_src.q.push_back(p);
    exp_q.push_back(exp_word(p));
  endtask : px
  task automatic drain;
    n = 0;
    while ((exp_q.size() > 0 || u_src.q.size() > 0) && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      summarize();
    end
  endtask : drain
  // ----------------------------------------------------------------
  // output monitor
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rstn_in && ce && out_valid === 1'b1 && out_ready) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("BAD extra_word exp 0 got 1");
      end else begin
        e = exp_q.pop_front();
        `CHK("colour", e.colour, colour)
        `CHK("blank", e.blank, blank_l)
        `CHK("sync", e.sync_on, sync_c)
        `CHK("pedestal", e.pedestal, ped_o)
      end
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(CTRL_OFS, 32'h1);
    rd(PAL_ADDR_OFS, 32'h0);
    rd(OVL_ADDR_OFS, 32'h1);
    apb(1'b0, 12'h018, '0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, r)
    apb(1'b1, PAL_ADDR_OFS, 32'hfe);
    for (int i = 0; i < 4; i++) begin
      c = 24'ha5c300 | 24'(i);
      pal_m[8'(254 + i)] = c;
      apb(1'b1, PAL_DATA_OFS, {8'h00, c});
    end
    rd(PAL_ADDR_OFS, 32'h2);
    apb(1'b1, PAL_ADDR_OFS, 32'h80);
    pal_m[8'h80] = 24'h3c0f80;
    apb(1'b1, PAL_DATA_OFS, 32'h003c0f80);
    apb(1'b1, OVL_ADDR_OFS, 32'h1);
    for (int i = 1; i < 16; i++) begin
      ovl_m[i] = 24'h0f00f0 + 24'(i) * 24'h010101;
      apb(1'b1, OVL_DATA_OFS, {8'h00, ovl_m[i]});
    end
    rd(OVL_ADDR_OFS, 32'h1);
    rd(OVL_DATA_OFS, {8'h00, ovl_m[1]});
    // every overlay code, then sync and blank combinations
    for (int i = 0; i < 16; i++) px(i == 0 ? 8'h80 : 8'h01, 4'(i), 1, 1);
    // blanked overlay word first: it stays the idle buffer head
    px(8'h00, 4'h7, 1'b0, 1'b0);
    px(8'h01, 4'h0, 1'b1, 1'b1);
    px(8'hff, 4'h0, 1'b0, 1'b1);
    px(8'hfe, 4'h0, 1'b1, 1'b0);
    drain();
    // far side stalls until the buffer refuses, zero pedestal
    ped <= 1'b0;
    out_ready <= 1'b0;
    // rewrite overlay 7 while the idle head selects it
    ovl_m[7] = 24'h96c35a;
    apb(1'b1, OVL_ADDR_OFS, 32'h7);
    apb(1'b1, OVL_DATA_OFS, {8'h00, ovl_m[7]});
    for (int i = 0; i < 9; i++) px(8'(254 + i % 4), 4'h0, 1'b1, 1'(i != 3));
    n = 0;
    while (pready_pix !== 1'b0 && n < 40) begin
      @(posedge clk_in);
      n++;
    end
    `CHK("ready_full", 1'b0, pready_pix)
    apb(1'b0, STATUS_OFS, '0);
    `CHK("fifo_count", 4'(FIFO_DEPTH), r[23:20])
    // enable low: nothing may leave even with the far side ready
    ce <= 1'b0;
    out_ready <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK("ce_freeze", 9, exp_q.size())
    ce <= 1'b1;
    u_src.slow = 1'b1;
    out_ready <= 1'b1;
    drain();
    // disabled converter blanks every pixel
    apb(1'b1, CTRL_OFS, 32'h0);
    en_v = 1'b0;
    px(8'h01, 4'h0, 1'b1, 1'b1);
    px(8'h00, 4'h3, 1'b0, 1'b1);
    drain();
    // rewrite entry 1 while the idle head indexes it
    apb(1'b1, PAL_ADDR_OFS, 32'h01);
    apb(1'b1, PAL_DATA_OFS, 32'h005a3c96);
    rd(PAL_ADDR_OFS, 32'h2);
    repeat (4) @(posedge clk_in);
    summarize();
  end
endmodule : palette_pixel_input_control_tb_top

// File: sim/pixel_source.sv
// graphics controller model feeding the pixel stream
`timescale 1ns/1ps
module pixel_source
  import palette_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ready_in,
  output logic valid_out,
  output pix_word_t word_out
);
  // ----------------------------------------------------------------
  // queue driven source, one word a cycle or one every other cycle
  // ----------------------------------------------------------------
  pix_word_t q[$];
  logic slow = 1'b0;
  logic skip_q = 1'b0;
  initial begin
    valid_out = 1'b0;
    word_out = '0;
  end
  // idle lines toggle so a stale word is never mistaken for a new one
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      valid_out <= 1'b0;
      word_out <= ~word_out;
    end else if (!valid_out || ready_in) begin
      if (q.size() > 0 && !(slow && skip_q)) begin
        // unused overlay lines arrive from the queue as zero
        word_out <= q.pop_front();
        valid_out <= 1'b1;
        skip_q <= 1'b1;
      end else begin
        valid_out <= 1'b0;
        word_out <= ~word_out;
        skip_q <= 1'b0;
      end
    end
  end
endmodule : pixel_source
